// *** cfm_defines.svh ***
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH
`define CFM_RAM_BYTES    17'h00800
`define CFM_HDR_BYTES    7'h08
`define CFM_TS_BYTES     7'h04
`define CFM_AREAS        32
`define CFM_A_CTRL       12'h000
`define CFM_A_TEF        12'h004
`define CFM_A_SEL        12'h008
`define CFM_A_FCFG       12'h00c
`define CFM_A_FSTA       12'h010
`define CFM_A_NEXT       12'h014
`define CFM_A_USAGE      12'h018
`define CFM_A_GO         12'h01c
`define CFM_A_T0         12'h020
`define CFM_A_T1         12'h024
`define CFM_A_DATA       12'h040
`define CFM_A_DATA_END   12'h07c
`define CFM_C_NORMAL     0
`define CFM_C_CLASSIC    1
`define CFM_C_QEN        2
`define CFM_C_EVEN       3
`define CFM_C_GW         4
`define CFM_C_MODE_LO    8
`define CFM_TEF_TS       5
`define CFM_F_PL_LO      8
`define CFM_F_DIR        12
`define CFM_F_RXTS       13
`define CFM_F_INC        16
`define CFM_S_CNT_LO     8
`define CFM_T1_ESI       8
`define CFM_T1_FDF       7
`define CFM_T1_BRS       6
`define CFM_T1_RTR       5
`define CFM_T1_IDE       4
`define CFM_T1_SEQ_LO    9
`define CFM_T0_EID_LO    11
`define CFM_CLASSIC_MAX  7'h08
`define CFM_RESP_OKAY    2'b00
`define CFM_RESP_SLVERR  2'b10
`endif

// *** cfm_pkg.sv ***
package cfm_pkg;
  typedef enum logic [1:0] {CFM_CONFIG, CFM_NORMAL, CFM_CLASSIC} cfm_mode_t;
  typedef enum logic {CFM_IDLE, CFM_SEND} cfm_txst_t;
  typedef struct packed {
    logic       dir;
    logic       rxts;
    logic [4:0] depth;
    logic [2:0] pl;
  } cfm_fcfg_t;

  function automatic logic [6:0] cfm_pl_bytes(input logic [2:0] code);
    logic [6:0] b;
    case (code)
      3'h0:    b = 7'h08;
      3'h1:    b = 7'h0c;
      3'h2:    b = 7'h10;
      3'h3:    b = 7'h14;
      3'h4:    b = 7'h18;
      3'h5:    b = 7'h20;
      3'h6:    b = 7'h30;
      default: b = 7'h40;
    endcase
    return b;
  endfunction

  function automatic logic [6:0] cfm_dlc_bytes(input logic [3:0] dlc);
    logic [6:0] b;
    case (dlc)
      4'h9:    b = 7'h0c;
      4'ha:    b = 7'h10;
      4'hb:    b = 7'h14;
      4'hc:    b = 7'h18;
      4'hd:    b = 7'h20;
      4'he:    b = 7'h30;
      4'hf:    b = 7'h40;
      default: b = {3'h0, dlc};
    endcase
    return b;
  endfunction
endpackage

// *** cfm_alloc_if.sv ***
`timescale 1ns/1ps
`include "cfm_defines.svh"
interface cfm_alloc_if;
  import cfm_pkg::*;
  cfm_fcfg_t   cfg [`CFM_AREAS];
  logic        q_en;
  logic        tef_en;
  logic        tef_ts;
  logic [4:0]  tef_depth;
  logic [4:0]  sel;
  logic [16:0] sel_base;
  logic [6:0]  sel_obj;
  logic [16:0] total;
  modport calc (input cfg, q_en, tef_en, tef_ts, tef_depth, sel,
                output sel_base, sel_obj, total);
  modport user (output cfg, q_en, tef_en, tef_ts, tef_depth, sel,
                input sel_base, sel_obj, total);
endinterface

// *** cfm_alloc.sv ***
`timescale 1ns/1ps
`include "cfm_defines.svh"
module cfm_alloc (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  cfm_alloc_if.calc   a
);
  import cfm_pkg::*;
  logic [16:0] base [`CFM_AREAS];
  logic [6:0]  obj  [`CFM_AREAS];
  logic [16:0] size [`CFM_AREAS];
  logic [16:0] tef_size;

  assign tef_size = a.tef_en ? 17'(({12'h0, a.tef_depth} + 17'h1) *
                    {10'h0, (a.tef_ts ? `CFM_HDR_BYTES + `CFM_TS_BYTES
                                      : `CFM_HDR_BYTES)}) : 17'h0;

  genvar i;
  for (i = 0; i < `CFM_AREAS; i++) begin : g_area
    assign obj[i] = `CFM_HDR_BYTES + cfm_pl_bytes(a.cfg[i].pl) +
                    ((a.cfg[i].rxts && !a.cfg[i].dir && i != 0)
                     ? `CFM_TS_BYTES : 7'h0);
    assign size[i] = (i == 0 && !a.q_en) ? 17'h0 :
                     17'(({12'h0, a.cfg[i].depth} + 17'h1) * {10'h0, obj[i]});
    if (i == 0) begin : g_first
      assign base[i] = tef_size;
    end else begin : g_next
      assign base[i] = base[i-1] + size[i-1];
    end
  end

  // no overflow check: host keeps total within capacity
  assign a.total    = base[`CFM_AREAS-1] + size[`CFM_AREAS-1];
  assign a.sel_base = base[a.sel];
  assign a.sel_obj  = obj[a.sel];

  a_txq_zero_space: assert property (@(posedge aclk) disable iff (!aresetn)
    !a.q_en |-> base[1] == base[0])
    else $error("queue takes space while disabled");
  a_tef_obj_size: assert property (@(posedge aclk) disable iff (!aresetn)
    (a.tef_en && a.tef_depth == 5'h0) |->
      base[0] == (a.tef_ts ? 17'h0000c : 17'h00008))
    else $error("event object size wrong");
  a_rx_stamp_space: assert property (@(posedge aclk) disable iff (!aresetn)
    a.cfg[1].dir |-> obj[1] == `CFM_HDR_BYTES + cfm_pl_bytes(a.cfg[1].pl))
    else $error("tx fifo got stamp space");
  a_area_in_ram: assert property (@(posedge aclk) disable iff (!aresetn)
    a.total <= `CFM_RAM_BYTES |->
      a.sel_base + {10'h0, a.sel_obj} <= `CFM_RAM_BYTES)
    else $error("selected area outside ram");
endmodule

// *** cfm_top.sv ***
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cfm_defines.svh"
module cfm_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              error_passive,
  input  wire logic              tx_obj_done,
  input  wire logic [4:0]        tx_obj_fifo,
  input  wire logic [4:0]        rx_store_fifo,
  output logic                   rx_store_stamp,
  output logic                   frame_start,
  output logic [28:0]            frame_id,
  output logic                   frame_ext,
  output logic                   frame_fd,
  output logic                   frame_brs,
  output logic                   frame_rtr,
  output logic                   frame_esi,
  output logic                   tx_byte_valid,
  input  wire logic              tx_byte_ready,
  output logic [7:0]             tx_byte,
  output logic                   event_seq_valid,
  output logic [22:0]            event_seq,
  output cfm_pkg::cfm_mode_t     op_mode
);
  import cfm_pkg::*;

  cfm_alloc_if al ();
  cfm_alloc u_alloc (.aclk(aclk), .aresetn(aresetn), .a(al.calc));

  // bus channel state
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        wr_fire, rd_fire, map_ok;
  logic [31:0] wmask, wnew, rdv;

  // configuration state
  cfm_mode_t   mode_q, mode_d;
  logic [4:0]  ctl_q, ctl_d;
  logic [5:0]  tef_q, tef_d;
  logic [4:0]  sel_q, sel_d;
  cfm_fcfg_t   cfg_q [`CFM_AREAS];
  logic [31:0] t0_q, t0_d, t1_q, t1_d;
  logic [31:0] dat_q [16];
  logic [4:0]  head_q [`CFM_AREAS];
  logic [5:0]  cnt_q [`CFM_AREAS];
  logic        in_cfg, wr_fcfg, inc_ok;

  // transmit state
  cfm_txst_t   st_q, st_d;
  logic [6:0]  idx_q, idx_d, left_q, left_d;
  logic [7:0]  byte_q, byte_d;
  logic        fs_q, fs_d, ev_q, ev_d, stamp_q;
  logic [28:0] id_q, id_d;
  logic        ext_q, ext_d, fd_q, fd_d, brs_q, brs_d, rtr_q, rtr_d;
  logic        esi_q, esi_d;
  logic [22:0] seq_q, seq_d;
  logic        go, fdv, rtrv;
  logic [6:0]  nbytes;

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign wr_fire = aw_q && w_q;
  assign rd_fire = s_axi_arvalid && !r_q;
  assign wmask   = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign in_cfg  = mode_q == CFM_CONFIG;

  function automatic logic decoded(input logic [11:0] ad);
    return ad == `CFM_A_CTRL || ad == `CFM_A_TEF || ad == `CFM_A_SEL ||
           ad == `CFM_A_FCFG || ad == `CFM_A_FSTA || ad == `CFM_A_NEXT ||
           ad == `CFM_A_USAGE || ad == `CFM_A_GO || ad == `CFM_A_T0 ||
           ad == `CFM_A_T1 ||
           (ad >= `CFM_A_DATA && ad <= `CFM_A_DATA_END && ad[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] reg_val(input logic [11:0] ad);
    logic [31:0] v;
    v = 32'h0;
    case (ad)
      `CFM_A_CTRL:  v = {22'h0, mode_q, 3'h0, ctl_q};
      `CFM_A_TEF:   v = {26'h0, tef_q};
      `CFM_A_SEL:   v = {27'h0, sel_q};
      `CFM_A_FCFG:  v = {18'h0, cfg_q[sel_q].rxts, cfg_q[sel_q].dir, 1'b0,
                         cfg_q[sel_q].pl, 3'h0, cfg_q[sel_q].depth};
      `CFM_A_FSTA:  v = {18'h0, cnt_q[sel_q], 7'h0,
                         cnt_q[sel_q] <= {1'b0, cfg_q[sel_q].depth}};
      `CFM_A_NEXT:  v = {15'h0, al.sel_base +
                         17'({12'h0, head_q[sel_q]} * {10'h0, al.sel_obj})};
      `CFM_A_USAGE: v = {15'h0, al.total};
      `CFM_A_GO:    v = {31'h0, st_q == CFM_SEND};
      `CFM_A_T0:    v = t0_q;
      `CFM_A_T1:    v = t1_q;
      default:      v = (ad >= `CFM_A_DATA && ad <= `CFM_A_DATA_END)
                        ? dat_q[ad[5:2]] : 32'h0;
    endcase
    return v;
  endfunction

  assign map_ok = decoded(awa_q);
  assign wnew   = (reg_val(awa_q) & ~wmask) | (wd_q & wmask);

  always_comb begin
    aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    b_d = b_q; br_d = br_q; r_d = r_q; rd_d = rd_q; rr_d = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = {s_axi_awaddr[11:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = map_ok ? `CFM_RESP_OKAY : `CFM_RESP_SLVERR;
    end else if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (rd_fire) begin
      r_d  = 1'b1;
      rd_d = reg_val({s_axi_araddr[11:2], 2'h0});
      rr_d = decoded({s_axi_araddr[11:2], 2'h0}) ? `CFM_RESP_OKAY
                                                  : `CFM_RESP_SLVERR;
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  assign wr_fcfg = wr_fire && awa_q == `CFM_A_FCFG;
  // increment only outside configuration, never past full
  assign inc_ok  = wr_fcfg && !in_cfg && wmask[`CFM_F_INC] &&
                   wd_q[`CFM_F_INC] &&
                   cnt_q[sel_q] <= {1'b0, cfg_q[sel_q].depth} &&
                   (sel_q != 5'h0 || ctl_q[`CFM_C_QEN]);

  always_comb begin
    mode_d = mode_q; ctl_d = ctl_q; tef_d = tef_q; sel_d = sel_q;
    t0_d = t0_q; t1_d = t1_q;
    if (wr_fire && awa_q == `CFM_A_CTRL) begin
      mode_d = !wnew[`CFM_C_NORMAL] ? CFM_CONFIG :
               wnew[`CFM_C_CLASSIC] ? CFM_CLASSIC : CFM_NORMAL;
      ctl_d[`CFM_C_CLASSIC] = wnew[`CFM_C_CLASSIC];
      ctl_d[`CFM_C_NORMAL]  = wnew[`CFM_C_NORMAL];
      ctl_d[`CFM_C_GW]      = wnew[`CFM_C_GW];
      if (in_cfg) begin
        ctl_d[`CFM_C_QEN]  = wnew[`CFM_C_QEN];
        ctl_d[`CFM_C_EVEN] = wnew[`CFM_C_EVEN];
      end
    end
    if (wr_fire && awa_q == `CFM_A_TEF && in_cfg)
      tef_d = wnew[5:0];
    if (wr_fire && awa_q == `CFM_A_SEL)
      sel_d = wnew[4:0];
    if (wr_fire && awa_q == `CFM_A_T0)
      t0_d = wnew;
    if (wr_fire && awa_q == `CFM_A_T1)
      t1_d = wnew;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 12'h0; wd_q <= 32'h0; ws_q <= 4'h0; rd_q <= 32'h0;
      br_q <= `CFM_RESP_OKAY; rr_q <= `CFM_RESP_OKAY;
      mode_q <= CFM_CONFIG; ctl_q <= 5'h0; tef_q <= 6'h0; sel_q <= 5'h0;
      t0_q <= 32'h0; t1_q <= 32'h0;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
      br_q <= br_d; rr_q <= rr_d;
      mode_q <= mode_d; ctl_q <= ctl_d; tef_q <= tef_d; sel_q <= sel_d;
      t0_q <= t0_d; t1_q <= t1_d;
    end
  end

  genvar gi;
  for (gi = 0; gi < `CFM_AREAS; gi++) begin : g_fifo
    cfm_fcfg_t  c_d;
    logic [4:0] h_d;
    logic [5:0] n_d;
    logic       hit_inc, hit_dec;
    assign hit_inc = inc_ok && sel_q == gi;
    assign hit_dec = tx_obj_done && tx_obj_fifo == gi && cnt_q[gi] != 6'h0;
    always_comb begin
      c_d = cfg_q[gi];
      h_d = head_q[gi];
      n_d = cnt_q[gi];
      if (wr_fcfg && in_cfg && sel_q == gi) begin
        c_d.depth = wnew[4:0];
        c_d.pl    = wnew[`CFM_F_PL_LO +: 3];
        c_d.dir   = (gi == 0) ? 1'b1 : wnew[`CFM_F_DIR];
        c_d.rxts  = (gi == 0) ? 1'b0 : wnew[`CFM_F_RXTS];
        h_d = 5'h0;
        n_d = 6'h0;
      end
      if (hit_inc)
        h_d = (head_q[gi] == cfg_q[gi].depth) ? 5'h0 : head_q[gi] + 5'h1;
      if (hit_inc && !hit_dec)
        n_d = cnt_q[gi] + 6'h1;
      else if (hit_dec && !hit_inc)
        n_d = cnt_q[gi] - 6'h1;
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_q[gi]  <= '{dir: (gi == 0), rxts: 1'b0, depth: 5'h0, pl: 3'h0};
        head_q[gi] <= 5'h0;
        cnt_q[gi]  <= 6'h0;
      end else begin
        cfg_q[gi]  <= c_d;
        head_q[gi] <= h_d;
        cnt_q[gi]  <= n_d;
      end
    end
  end

  for (gi = 0; gi < 16; gi++) begin : g_data
    always_ff @(posedge aclk) begin
      if (!aresetn)
        dat_q[gi] <= 32'h0;
      else if (wr_fire && awa_q == `CFM_A_DATA + 12'(gi * 4))
        dat_q[gi] <= wnew;
    end
  end

  assign al.cfg       = cfg_q;
  assign al.q_en      = ctl_q[`CFM_C_QEN];
  assign al.tef_en    = ctl_q[`CFM_C_EVEN];
  assign al.tef_ts    = tef_q[`CFM_TEF_TS];
  assign al.tef_depth = tef_q[4:0];
  assign al.sel       = sel_q;

  // stamp only receive fifos with stamping on
  always_ff @(posedge aclk) begin
    if (!aresetn)
      stamp_q <= 1'b0;
    else
      stamp_q <= rx_store_fifo != 5'h0 && !cfg_q[rx_store_fifo].dir &&
                 cfg_q[rx_store_fifo].rxts;
  end
  assign rx_store_stamp = stamp_q;

  assign fdv  = t1_q[`CFM_T1_FDF] && mode_q == CFM_NORMAL;
  // remote request only in classic frames
  assign rtrv = t1_q[`CFM_T1_RTR] && !fdv;
  // byte count from dlc, classic capped
  assign nbytes = rtrv ? 7'h0 :
                  (!fdv && cfm_dlc_bytes(t1_q[3:0]) > `CFM_CLASSIC_MAX)
                  ? `CFM_CLASSIC_MAX : cfm_dlc_bytes(t1_q[3:0]);
  assign go = wr_fire && awa_q == `CFM_A_GO && wnew[0] && !in_cfg &&
              st_q == CFM_IDLE;

  always_comb begin
    st_d = st_q; idx_d = idx_q; left_d = left_q; byte_d = byte_q;
    fs_d = 1'b0; ev_d = 1'b0; id_d = id_q; ext_d = ext_q; fd_d = fd_q;
    brs_d = brs_q; rtr_d = rtr_q; esi_d = esi_q; seq_d = seq_q;
    case (st_q)
      CFM_IDLE: begin
        if (go) begin
          fs_d  = 1'b1;
          id_d  = t0_q[28:0];
          ext_d = t1_q[`CFM_T1_IDE];
          fd_d  = fdv;
          rtr_d = rtrv;
          // rate switch only inside fd frames
          brs_d = fdv && t1_q[`CFM_T1_BRS];
          // esi from own state, gateway or-ed
          esi_d = error_passive ||
                  (ctl_q[`CFM_C_GW] && t1_q[`CFM_T1_ESI]);
          // tag kept aside, never on the bus
          seq_d = t1_q[31:`CFM_T1_SEQ_LO];
          idx_d = 7'h0;
          left_d = nbytes;
          byte_d = dat_q[0][7:0];
          if (nbytes != 7'h0)
            st_d = CFM_SEND;
          else
            ev_d = ctl_q[`CFM_C_EVEN];
        end
      end
      CFM_SEND: begin
        if (tx_byte_ready) begin
          idx_d  = idx_q + 7'h1;
          left_d = left_q - 7'h1;
          byte_d = dat_q[idx_d[5:2]][{idx_d[1:0], 3'h0} +: 8];
          if (left_q == 7'h1) begin
            st_d = CFM_IDLE;
            ev_d = ctl_q[`CFM_C_EVEN];
          end
        end
      end
      default: st_d = CFM_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CFM_IDLE; idx_q <= 7'h0; left_q <= 7'h0; byte_q <= 8'h0;
      fs_q <= 1'b0; ev_q <= 1'b0; id_q <= 29'h0; ext_q <= 1'b0;
      fd_q <= 1'b0; brs_q <= 1'b0; rtr_q <= 1'b0; esi_q <= 1'b0;
      seq_q <= 23'h0;
    end else begin
      st_q <= st_d; idx_q <= idx_d; left_q <= left_d; byte_q <= byte_d;
      fs_q <= fs_d; ev_q <= ev_d; id_q <= id_d; ext_q <= ext_d;
      fd_q <= fd_d; brs_q <= brs_d; rtr_q <= rtr_d; esi_q <= esi_d;
      seq_q <= seq_d;
    end
  end

  assign frame_start     = fs_q;
  assign frame_id        = id_q;
  assign frame_ext       = ext_q;
  assign frame_fd        = fd_q;
  assign frame_brs       = brs_q;
  assign frame_rtr       = rtr_q;
  assign frame_esi       = esi_q;
  assign tx_byte_valid   = st_q == CFM_SEND;
  assign tx_byte         = byte_q;
  assign event_seq_valid = ev_q;
  assign event_seq       = seq_q;
  assign op_mode         = mode_q;

  // helper: bytes moved in current frame
  logic [6:0] sent_q, want_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || go)
      sent_q <= 7'h0;
    else if (tx_byte_valid && tx_byte_ready)
      sent_q <= sent_q + 7'h1;
  end
  // count fixed at start, so a broken down-count shows
  always_ff @(posedge aclk) begin
    if (!aresetn)
      want_q <= 7'h0;
    else if (go)
      want_q <= nbytes;
  end

  sequence s_go;
    go;
  endsequence
  sequence s_last_byte;
    tx_byte_valid && tx_byte_ready && left_q == 7'h1;
  endsequence

  a_alloc_cfg_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_cfg |=> $stable(tef_q) && $stable(ctl_q[`CFM_C_QEN]))
    else $error("allocation changed outside configuration");
  a_ide_format: assert property (@(posedge aclk) disable iff (!aresetn)
    s_go |=> frame_start && frame_ext == $past(t1_q[`CFM_T1_IDE]))
    else $error("frame format mismatch");
  a_fd_classic: assert property (@(posedge aclk) disable iff (!aresetn)
    s_go ##0 (mode_q == CFM_CLASSIC) |=> !frame_fd)
    else $error("fd frame in classic mode");
  a_brs_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    s_go |=> frame_brs == (frame_fd && $past(t1_q[`CFM_T1_BRS])))
    else $error("rate switch wrong");
  a_rtr_classic: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_start |-> !(frame_rtr && frame_fd))
    else $error("remote request in fd frame");
  a_esi_own: assert property (@(posedge aclk) disable iff (!aresetn)
    s_go ##0 !ctl_q[`CFM_C_GW] |=> frame_esi == $past(error_passive))
    else $error("esi not from own state");
  a_esi_gateway: assert property (@(posedge aclk) disable iff (!aresetn)
    s_go ##0 (ctl_q[`CFM_C_GW] && t1_q[`CFM_T1_ESI]) |=> frame_esi)
    else $error("gateway esi not recessive");
  a_byte_count: assert property (@(posedge aclk) disable iff (!aresetn)
    s_last_byte |=> sent_q == want_q && st_q == CFM_IDLE)
    else $error("payload byte count wrong");
  a_seq_to_event: assert property (@(posedge aclk) disable iff (!aresetn)
    s_go |=> event_seq == $past(t1_q[31:`CFM_T1_SEQ_LO]))
    else $error("sequence tag not copied");
  a_event_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
    s_last_byte ##0 ctl_q[`CFM_C_EVEN] |=> event_seq_valid)
    else $error("event not raised after last byte");
endmodule

// *** cfm_far_end.sv ***
`timescale 1ns/1ps
module cfm_far_end (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic frame_start,
  input  wire logic tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic event_seq_valid,
  output logic      tx_byte_ready,
  output logic      tx_obj_done,
  output logic [4:0] tx_obj_fifo
);
  logic [7:0] bytes [64];
  int         n;
  int         idx;
  assign tx_obj_fifo = 5'h00;
  // stalls every other cycle, so byte hold is exercised
  always @(posedge aclk) begin
    idx = frame_start ? 0 : n;
    tx_byte_ready <= aresetn & ~tx_byte_ready;
    tx_obj_done <= aresetn & event_seq_valid;
    if (tx_byte_valid && tx_byte_ready) begin
      bytes[idx] <= tx_byte;
      n <= idx + 1;
    end else begin
      n <= idx;
    end
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "cfm_defines.svh"
module tb_top;
  import cfm_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, epass, evv;
  logic        stamp, fstart, ext, fd, brs, rtr, esi, bval, brdy, done;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  rxf, objf;
  logic [28:0] fid;
  logic [7:0]  tbyte;
  logic [22:0] seq;
  cfm_mode_t   mode;
  int          mismatches, checked, evs;
  cfm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .error_passive(epass), .tx_obj_done(done),
    .tx_obj_fifo(objf), .rx_store_fifo(rxf), .rx_store_stamp(stamp),
    .frame_start(fstart), .frame_id(fid), .frame_ext(ext), .frame_fd(fd),
    .frame_brs(brs), .frame_rtr(rtr), .frame_esi(esi),
    .tx_byte_valid(bval), .tx_byte_ready(brdy), .tx_byte(tbyte),
    .event_seq_valid(evv), .event_seq(seq), .op_mode(mode));
  cfm_far_end far (.aclk(aclk), .aresetn(aresetn), .frame_start(fstart),
    .tx_byte_valid(bval), .tx_byte(tbyte), .event_seq_valid(evv),
    .tx_byte_ready(brdy), .tx_obj_done(done), .tx_obj_fifo(objf));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // counts event pulses, so a pulse under a bus wait is not lost
  always @(posedge aclk) begin
    if (evv === 1'b1) evs <= evs + 1;
  end
  task end_sim;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // each channel held to its own ready edge; only the watchdog ends a wait
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        b = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task rdr(input logic [11:0] a);
    logic r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        r = 1'b1;
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task send(input logic [31:0] t1, input logic [4:0] f, input int nb,
            input logic [22:0] s);
    int k, e;
    e = evs;
    wr(`CFM_A_T1, t1);
    for (k = 0; k < (nb + 3) / 4; k++) begin
      wr(12'(`CFM_A_DATA + 4 * k), {8'(4*k+4), 8'(4*k+3), 8'(4*k+2),
                                    8'(4*k+1)});
    end
    wr(`CFM_A_GO, 32'h1);
    k = 0;
    while (evs == e && k < 300) begin
      @(posedge aclk);
      k++;
    end
    chk(32'(evs - e), 32'h1);
    chk({fd, brs, ext, rtr, esi}, f);
    chk(seq, s);
    chk(32'(far.n), 32'(nb));
    for (k = 0; k < nb; k++) chk(far.bytes[k], k + 1);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, epass} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    rxf = 5'h00;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`CFM_A_CTRL);
    chk(rd, 32'h0);
    // layout: event 2x12, queue 3x24, fifo1 rx stamped 20, 30 spare x16
    wr(`CFM_A_TEF, 32'h20);
    wr(`CFM_A_CTRL, 32'hc);
    wr(`CFM_A_TEF, 32'h21);
    wr(`CFM_A_SEL, 32'h0);
    wr(`CFM_A_FCFG, 32'h202);
    wr(`CFM_A_SEL, 32'h1);
    wr(`CFM_A_FCFG, 32'h2000);
    rdr(`CFM_A_USAGE);
    chk(rd, 32'h254);
    rdr(`CFM_A_NEXT);
    chk(rd, 32'h60);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      rxf <= 5'(i);
      @(posedge aclk);
      @(negedge aclk);
      chk(stamp, i == 1);
    end
    wr(`CFM_A_CTRL, 32'h1d);
    wr(`CFM_A_TEF, 32'h1f);
    chk(32'(rs), 32'h0);
    rdr(`CFM_A_USAGE);
    chk(rd, 32'h254);
    rdr(`CFM_A_CTRL);
    chk(rd, 32'h11d);
    wr(`CFM_A_SEL, 32'h0);
    rdr(`CFM_A_FSTA);
    chk(rd, 32'h001);
    wr(`CFM_A_FCFG, 32'h10000);
    rdr(`CFM_A_FSTA);
    chk(rd, 32'h101);
    rdr(`CFM_A_NEXT);
    chk(32'h400 + rd, 32'h430);
    wr(`CFM_A_T0, 32'h1abcdef5);
    send(32'habd9, 5'b11101, 12, 23'h55);
    chk(fid, 32'h1abcdef5);
    // unmapped: error answer, no effect, no stale data
    wr(12'h100, 32'h5a);
    chk(32'(rs), 32'h2);
    rdr(12'h100);
    chk(32'(rs), 32'h2);
    chk(rd, 32'h0);
    rdr(`CFM_A_FSTA);
    chk(rd, 32'h001);
    send(32'h6a2, 5'b10000, 2, 23'h3);
    wr(`CFM_A_CTRL, 32'h0f);
    chk(mode, CFM_CLASSIC);
    epass <= 1'b1;
    send(32'hfcf, 5'b00001, 8, 23'h7);
    epass <= 1'b0;
    send(32'h124, 5'b00010, 0, 23'h0);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim;
  end
endmodule
